/* include/stepper_pkg.sv */
`default_nettype none
package stepper_pkg;

    localparam int CLK_PERIOD_NS = 50;
    localparam int OFF_TIME_NS = 48000;
    localparam int OFF_TIME_CYC = (OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESTART_DELAY_NS = 3000;
    localparam int RESTART_DELAY_CYC = (RESTART_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 10;

    localparam int NUM_WINDINGS = 2;
    localparam int WIND_A = 0;
    localparam int WIND_B = 1;
    localparam int CODE_W = 4;

    localparam int FAULT_W = 3;
    localparam int FAULT_OVC = 0;
    localparam int FAULT_THERMAL = 1;
    localparam int FAULT_UVLO = 2;

    localparam logic [CODE_W-1:0] LEVEL_1P000 = 4'hf;
    localparam logic [CODE_W-1:0] LEVEL_0P924 = 4'he;
    localparam logic [CODE_W-1:0] LEVEL_0P707 = 4'hb;
    localparam logic [CODE_W-1:0] LEVEL_0P383 = 4'h6;
    localparam logic [CODE_W-1:0] LEVEL_ZERO = 4'h0;

    localparam int AXI_ADDR_W = 8;
    localparam logic [AXI_ADDR_W-1:0] CTRL_OFFSET = 8'h00;
    localparam logic [AXI_ADDR_W-1:0] STEP_OFFSET = 8'h04;
    localparam logic [AXI_ADDR_W-1:0] STATUS_OFFSET = 8'h08;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_BRAKE_BIT = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam int STEP_FWD_BIT = 0;
    localparam int STEP_REV_BIT = 1;
    localparam int STATUS_INDEX_LSB = 0;
    localparam int STATUS_FAULT_LSB = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    typedef enum logic [2:0] {
        MODE_WAVE,
        MODE_TWO_PHASE,
        MODE_HALF,
        MODE_HALF_COMP,
        MODE_QUARTER
    } step_mode_t;

    typedef enum logic [1:0] {
        OVC_RUN,
        OVC_TRIPPED,
        OVC_RESTART
    } ovc_state_t;

endpackage
`default_nettype wire

/* include/stepper_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface stepper_link_if
    import stepper_pkg::*;
(
    input wire logic aclk
);
    // Bit 3 is current_code_bit3 (MSB) down to bit 0, current_code_bit0
    logic [NUM_WINDINGS-1:0][CODE_W-1:0] current_code;
    logic [NUM_WINDINGS-1:0] direction;
    logic [NUM_WINDINGS-1:0] brake;
    logic [FAULT_W-1:0] fault;

    modport controller (
        output current_code,
        output direction,
        output brake,
        input fault
    );

    modport driver (
        input current_code,
        input direction,
        input brake,
        output fault
    );
endinterface
`default_nettype wire

/* rtl/stepper_driver.sv */
`timescale 1ns/1ps
`default_nettype none
module stepper_driver
    import stepper_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    stepper_link_if.driver link,
    input wire logic [NUM_WINDINGS-1:0] chop_trip,
    input wire logic [NUM_WINDINGS-1:0] overcurrent_trip,
    input wire logic [NUM_WINDINGS-1:0] fault_current_zero,
    input wire logic temp_above_shutdown,
    input wire logic temp_above_restart,
    input wire logic supply_low,
    output logic [NUM_WINDINGS-1:0] source1_on,
    output logic [NUM_WINDINGS-1:0] source2_on,
    output logic [NUM_WINDINGS-1:0] sink1_on,
    output logic [NUM_WINDINGS-1:0] sink2_on,
    output logic [NUM_WINDINGS-1:0][CODE_W-1:0] chop_threshold_code
);
    localparam int PIN_W = 3 * NUM_WINDINGS + 3;

    logic [PIN_W-1:0] pin_meta_reg;
    logic [PIN_W-1:0] pin_sync_reg;
    logic [NUM_WINDINGS-1:0] chop_s, ovc_s, zero_s;
    logic hot_s, warm_s, low_s;
    logic thermal_reg;
    logic uvlo_reg;
    logic [NUM_WINDINGS-1:0] ovc_run;
    logic [FAULT_W-1:0] fault_reg;

    // Comparator pins are asynchronous to aclk
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= {chop_trip, overcurrent_trip, fault_current_zero,
                             temp_above_shutdown, temp_above_restart, supply_low};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign {chop_s, ovc_s, zero_s, hot_s, warm_s, low_s} = pin_sync_reg;

    // Hysteresis comes from the two temperature comparators
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            thermal_reg <= 1'b0;
        end else if (hot_s) begin
            thermal_reg <= 1'b1;
        end else if (!warm_s) begin
            thermal_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            uvlo_reg <= 1'b0;
        end else begin
            uvlo_reg <= low_s;
        end
    end

    // A lasting short keeps restarting, so heating ends in thermal cycling
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_reg <= '0;
        end else begin
            fault_reg[FAULT_OVC] <= ~&ovc_run;
            fault_reg[FAULT_THERMAL] <= thermal_reg;
            fault_reg[FAULT_UVLO] <= uvlo_reg;
        end
    end

    assign link.fault = fault_reg;

    for (genvar ch = 0; ch < NUM_WINDINGS; ch++) begin : g_chan
        ovc_state_t ovc_state_reg;
        logic [TIMER_W-1:0] restart_cnt_reg;
        logic [TIMER_W-1:0] off_cnt_reg;
        logic off_time_pulse;
        logic bridge_on;

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ovc_state_reg <= OVC_RUN;
                restart_cnt_reg <= '0;
            end else begin
                unique case (ovc_state_reg)
                    OVC_RUN: begin
                        if (ovc_s[ch]) begin
                            ovc_state_reg <= OVC_TRIPPED;
                        end
                    end
                    OVC_TRIPPED: begin
                        if (zero_s[ch]) begin
                            ovc_state_reg <= OVC_RESTART;
                            restart_cnt_reg <= TIMER_W'(RESTART_DELAY_CYC - 1);
                        end
                    end
                    OVC_RESTART: begin
                        if (restart_cnt_reg == '0) begin
                            ovc_state_reg <= OVC_RUN;
                        end else begin
                            restart_cnt_reg <= restart_cnt_reg - 1'b1;
                        end
                    end
                endcase
            end
        end

        assign ovc_run[ch] = (ovc_state_reg == OVC_RUN);

        // Fixed off-time; a trip during the pulse is ignored, not stretched
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                off_cnt_reg <= '0;
            end else if (off_cnt_reg != '0) begin
                off_cnt_reg <= off_cnt_reg - 1'b1;
            end else if (chop_s[ch]) begin
                off_cnt_reg <= TIMER_W'(OFF_TIME_CYC);
            end
        end

        assign off_time_pulse = (off_cnt_reg != '0);
        assign bridge_on = !thermal_reg && !uvlo_reg && ovc_run[ch];

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                source1_on[ch] <= 1'b0;
                source2_on[ch] <= 1'b0;
                sink1_on[ch] <= 1'b0;
                sink2_on[ch] <= 1'b0;
                chop_threshold_code[ch] <= '0;
            end else begin
                chop_threshold_code[ch] <= link.current_code[ch];
                if (!bridge_on) begin
                    source1_on[ch] <= 1'b0;
                    source2_on[ch] <= 1'b0;
                    sink1_on[ch] <= 1'b0;
                    sink2_on[ch] <= 1'b0;
                end else if (link.brake[ch]) begin
                    source1_on[ch] <= 1'b1;
                    source2_on[ch] <= 1'b1;
                    sink1_on[ch] <= 1'b0;
                    sink2_on[ch] <= 1'b0;
                end else begin
                    source1_on[ch] <= !link.direction[ch];
                    source2_on[ch] <= link.direction[ch];
                    sink1_on[ch] <= link.direction[ch] && !off_time_pulse;
                    sink2_on[ch] <= !link.direction[ch] && !off_time_pulse;
                end
            end
        end
    end

endmodule
`default_nettype wire

/* rtl/stepper_controller.sv */
// Operation
// - Driver drops both sources above overcurrent
// - Driver restarts alone after fault current zero
// - Persistent short ends in thermal cycling
// - Driver disables bridge above thermal threshold
// - Driver re-enables bridge below hysteresis threshold
// - Driver holds bridge off during undervoltage
// - Wave drive walks A, B, A-, B-
// - Reverse walks the same sequence backwards
// - Two-phase walks AB, A-B, A-B-, AB-
// - Uncompensated half step uses eight states
// - Compensated half step uses 45-degree angles
// - Levels follow rounded cosine and sine
// - Direction bits follow angle quadrant
// - Quarter step uses 22.5-degree angles
// - Brake stays low in microstep modes
// - Code sets chop threshold as D/16
// - Brake or direction selects the switches
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module stepper_controller
    import stepper_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    stepper_link_if.controller link
);
    logic aw_full_reg;
    logic w_full_reg;
    logic [AXI_ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic do_write;
    logic wr_mapped;
    logic ctrl_wr;
    logic step_fwd;
    logic step_rev;
    logic [7:0] ctrl_reg;
    step_mode_t mode;
    logic [3:0] index_reg;
    logic [3:0] index_next;
    logic [3:0] last_index;
    logic [3:0] angle;
    logic full_level;
    logic [31:0] rdata_next;
    logic rd_mapped;
    logic [NUM_WINDINGS-1:0][CODE_W-1:0] code_reg;
    logic [NUM_WINDINGS-1:0] dir_reg;
    logic [NUM_WINDINGS-1:0] brake_reg;

    // Magnitude for a quarter-cycle position 0..4 of 22.5 degrees
    function automatic logic [CODE_W-1:0] magnitude(input logic [2:0] pos);
        logic [CODE_W-1:0] m;
        m = LEVEL_ZERO;
        unique case (pos)
            3'h0: m = LEVEL_1P000;
            3'h1: m = LEVEL_0P924;
            3'h2: m = LEVEL_0P707;
            3'h3: m = LEVEL_0P383;
            default: m = LEVEL_ZERO;
        endcase
        return m;
    endfunction

    // Write channel: address and data may arrive in either order
    assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign wr_mapped = (awaddr_reg[AXI_ADDR_W-1:2] == CTRL_OFFSET[AXI_ADDR_W-1:2]) ||
                       (awaddr_reg[AXI_ADDR_W-1:2] == STEP_OFFSET[AXI_ADDR_W-1:2]) ||
                       (awaddr_reg[AXI_ADDR_W-1:2] == STATUS_OFFSET[AXI_ADDR_W-1:2]);
    assign ctrl_wr = do_write && wstrb_reg[0] &&
                     (awaddr_reg[AXI_ADDR_W-1:2] == CTRL_OFFSET[AXI_ADDR_W-1:2]);
    assign step_fwd = do_write && wstrb_reg[0] && wdata_reg[STEP_FWD_BIT] && !wdata_reg[STEP_REV_BIT] &&
                      (awaddr_reg[AXI_ADDR_W-1:2] == STEP_OFFSET[AXI_ADDR_W-1:2]);
    assign step_rev = do_write && wstrb_reg[0] && wdata_reg[STEP_REV_BIT] && !wdata_reg[STEP_FWD_BIT] &&
                      (awaddr_reg[AXI_ADDR_W-1:2] == STEP_OFFSET[AXI_ADDR_W-1:2]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            awaddr_reg <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_full_reg <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_full_reg <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_reg <= wdata_reg[7:0];
        end
    end

    // Unused codes fall back to wave drive rather than stalling the motor
    always_comb begin
        unique case (ctrl_reg[CTRL_MODE_LSB +: 3])
            3'h1: mode = MODE_TWO_PHASE;
            3'h2: mode = MODE_HALF;
            3'h3: mode = MODE_HALF_COMP;
            3'h4: mode = MODE_QUARTER;
            default: mode = MODE_WAVE;
        endcase
    end

    always_comb begin
        last_index = 4'h3;
        unique case (mode)
            MODE_WAVE, MODE_TWO_PHASE: last_index = 4'h3;
            MODE_HALF, MODE_HALF_COMP: last_index = 4'h7;
            MODE_QUARTER: last_index = 4'hf;
        endcase
    end

    always_comb begin
        index_next = index_reg;
        if (step_fwd) begin
            index_next = (index_reg == last_index) ? 4'h0 : index_reg + 4'h1;
        end else if (step_rev) begin
            index_next = (index_reg == 4'h0) ? last_index : index_reg - 4'h1;
        end
    end

    // A mode change restarts the cycle so the index never exceeds its length
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            index_reg <= '0;
        end else if (ctrl_wr) begin
            index_reg <= '0;
        end else begin
            index_reg <= index_next;
        end
    end

    // Every mode maps to a 22.5-degree angle; full-step and uncompensated half-step modes saturate the level
    always_comb begin
        angle = index_reg;
        full_level = 1'b1;
        unique case (mode)
            MODE_WAVE: angle = {index_reg[1:0], 2'h0};
            MODE_TWO_PHASE: angle = {index_reg[1:0], 2'h2};
            MODE_HALF: angle = {index_reg[2:0], 1'b0};
            MODE_HALF_COMP: begin
                angle = {index_reg[2:0], 1'b0};
                full_level = 1'b0;
            end
            MODE_QUARTER: begin
                angle = index_reg;
                full_level = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code_reg <= '0;
            dir_reg <= '0;
            brake_reg <= '0;
        end else if (!ctrl_reg[CTRL_ENABLE_BIT]) begin
            code_reg <= '0;
            dir_reg <= '0;
            brake_reg <= '0;
        end else begin
            for (int w = 0; w < NUM_WINDINGS; w++) begin
                logic [CODE_W-1:0] m;
                m = magnitude((w == WIND_A) ? (angle[2] ? 3'(4'h4 - {2'h0, angle[1:0]}) : {1'b0, angle[1:0]})
                                            : (angle[2] ? {1'b0, angle[1:0]} : 3'(4'h4 - {2'h0, angle[1:0]})));
                code_reg[w] <= (full_level && m != LEVEL_ZERO) ? LEVEL_1P000 : m;
            end
            dir_reg[WIND_A] <= (angle <= 4'h3) || (angle >= 4'hc);
            dir_reg[WIND_B] <= (angle <= 4'h7);
            brake_reg <= (mode == MODE_HALF_COMP || mode == MODE_QUARTER) ? '0 :
                         {NUM_WINDINGS{ctrl_reg[CTRL_BRAKE_BIT]}};
        end
    end

    assign link.current_code = code_reg;
    assign link.direction = dir_reg;
    assign link.brake = brake_reg;

    // Read channel
    assign rd_mapped = (s_axi_araddr[AXI_ADDR_W-1:2] == CTRL_OFFSET[AXI_ADDR_W-1:2]) ||
                       (s_axi_araddr[AXI_ADDR_W-1:2] == STEP_OFFSET[AXI_ADDR_W-1:2]) ||
                       (s_axi_araddr[AXI_ADDR_W-1:2] == STATUS_OFFSET[AXI_ADDR_W-1:2]);

    always_comb begin
        rdata_next = '0;
        if (s_axi_araddr[AXI_ADDR_W-1:2] == CTRL_OFFSET[AXI_ADDR_W-1:2]) begin
            rdata_next[7:0] = ctrl_reg;
        end else if (s_axi_araddr[AXI_ADDR_W-1:2] == STATUS_OFFSET[AXI_ADDR_W-1:2]) begin
            rdata_next[STATUS_INDEX_LSB +: 4] = index_reg;
            rdata_next[STATUS_FAULT_LSB +: FAULT_W] = link.fault;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_next;
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule
`default_nettype wire

/* verif/stepper_link_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module stepper_link_properties
    import stepper_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [NUM_WINDINGS-1:0][CODE_W-1:0] current_code,
    input wire logic [NUM_WINDINGS-1:0] direction,
    input wire logic [NUM_WINDINGS-1:0] brake,
    input wire logic [FAULT_W-1:0] fault
);
    logic [7:0] ovc_cnt_reg;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Saturates so that a long short circuit cannot wrap the count back to a small value
    always_ff @(posedge aclk) begin
        if (!aresetn || !fault[FAULT_OVC]) begin
            ovc_cnt_reg <= 8'h00;
        end else if (ovc_cnt_reg != 8'hff) begin
            ovc_cnt_reg <= ovc_cnt_reg + 8'h01;
        end
    end

    code_pair_a: assert property ({current_code[WIND_A], current_code[WIND_B]} inside
        {8'hf0, 8'h0f, 8'hff, 8'hbb, 8'he6, 8'h6e, 8'h00})
        else $error("winding level pair outside the sine table");
    dir_axis_a: assert property ({current_code[WIND_A], current_code[WIND_B]} == 8'hf0
        |-> direction[WIND_A] == direction[WIND_B])
        else $error("directions disagree on the A axis");
    dir_cross_a: assert property ({current_code[WIND_A], current_code[WIND_B]} == 8'h0f
        |-> direction[WIND_A] != direction[WIND_B])
        else $error("directions agree on the B axis");
    brake_pair_a: assert property (brake[WIND_A] == brake[WIND_B])
        else $error("brake differs between windings");
    brake_level_a: assert property (|brake |-> current_code[WIND_A] inside {4'h0, 4'hf}
        && current_code[WIND_B] inside {4'h0, 4'hf})
        else $error("brake raised with a microstep level");
    idle_off_a: assert property (current_code == '0 |-> direction == '0 && brake == '0)
        else $error("idle link still drives direction or brake");
    step_spacing_a: assert property ($changed(current_code) |=> $stable(current_code))
        else $error("levels changed on two edges in a row");
    ovc_hold_a: assert property ($fell(fault[FAULT_OVC]) |-> ovc_cnt_reg >= 8'(RESTART_DELAY_CYC))
        else $error("overcurrent restart came too early");
endmodule
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
    import stepper_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [1:0] chop_trip = '0, overcurrent_trip = '0, fault_current_zero = '0;
    logic temp_above_shutdown = 0, temp_above_restart = 0, supply_low = 0;
    logic [1:0] source1_on, source2_on, sink1_on, sink2_on;
    logic [NUM_WINDINGS-1:0][CODE_W-1:0] chop_threshold_code;
    int error_cnt = 0, n_checks = 0, idx, len, m, k, s;
    logic brk;
    logic [31:0] rd, ctrl;
    logic [1:0] rr;

    always #25 aclk = ~aclk;

    stepper_link_if link (.aclk(aclk));
    stepper_controller i_stepper_controller (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .link(link));
    stepper_driver i_stepper_driver (.aclk, .aresetn, .link(link), .chop_trip, .overcurrent_trip,
        .fault_current_zero, .temp_above_shutdown, .temp_above_restart, .supply_low, .source1_on, .source2_on,
        .sink1_on, .sink2_on, .chop_threshold_code);
    stepper_link_properties i_stepper_link_properties (.aclk, .aresetn, .current_code(link.current_code),
        .direction(link.direction), .brake(link.brake), .fault(link.fault));

    task automatic tally_and_finish();
        if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    // Handshakes are judged at the falling edge, where the values that the next rising edge samples stand settled
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic a_h, w_h, b_h;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        b_h = 0;
        while (!b_h) begin
            @(negedge aclk);
            a_h = s_axi_awvalid && s_axi_awready;
            w_h = s_axi_wvalid && s_axi_wready;
            b_h = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge aclk);
            if (a_h) s_axi_awvalid <= 0;
            if (w_h) s_axi_wvalid <= 0;
            if (b_h) s_axi_bready <= 0;
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic a_h, r_h;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        r_h = 0;
        while (!r_h) begin
            @(negedge aclk);
            a_h = s_axi_arvalid && s_axi_arready;
            r_h = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (a_h) s_axi_arvalid <= 0;
            if (r_h) s_axi_rready <= 0;
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask

    // Angle in 22.5 degree units; full-step and uncompensated half-step modes saturate any nonzero level
    task automatic check_all();
        logic [3:0] lvl [8] = '{4'hf, 4'he, 4'hb, 4'h6, 4'h0, 4'h6, 4'hb, 4'he};
        logic [3:0] ca, cb;
        logic [1:0] ed, eb;
        logic [31:0] sr;
        logic [1:0] sresp;
        int q;
        q = (m == 0) ? idx * 4 : (m == 1) ? 2 + idx * 4 : (m < 4) ? idx * 2 : idx;
        ca = lvl[q % 8];
        cb = lvl[(q + 4) % 8];
        if (m < 3) begin
            ca = (ca != 0) ? 4'hf : 4'h0;
            cb = (cb != 0) ? 4'hf : 4'h0;
        end
        ed = {q < 8, q <= 3 || q >= 12};
        eb = {2{brk && m < 3}};
        settle(0);
        chk("code", {cb, ca}, link.current_code);
        chk("dir", ed, link.direction);
        chk("brake", eb, link.brake);
        settle(5);
        chk("threshold", {cb, ca}, chop_threshold_code);
        chk("source1", 2'(eb | ~ed), source1_on);
        chk("source2", 2'(eb | ed), source2_on);
        chk("sink1", 2'(~eb & ed), sink1_on);
        chk("sink2", 2'(~eb & ~ed), sink2_on);
        axi_rd(STATUS_OFFSET, sr, sresp);
        chk("index", idx, sr[3:0]);
    endtask

    initial begin
        void'($urandom(32'h8e72));
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        axi_rd(CTRL_OFFSET, rd, rr);
        chk("ctrl reset", CTRL_RESET, rd);
        axi_wr(8'h0c, 32'h1, rr);
        chk("unmapped bresp", RESP_SLVERR, rr);
        axi_rd(8'h10, rd, rr);
        chk("unmapped rresp", RESP_SLVERR, rr);
        chk("unmapped rdata", 0, rd);
        for (m = 0; m < 5; m++) begin
            brk = (m == 1 || m == 3);
            len = (m < 2) ? 4 : (m < 4) ? 8 : 16;
            ctrl = 32'h1 | (32'(brk) << 1) | (32'(m) << 2);
            axi_wr(CTRL_OFFSET, ctrl, rr);
            chk("ctrl bresp", RESP_OKAY, rr);
            idx = 0;
            axi_rd(CTRL_OFFSET, rd, rr);
            chk("ctrl", ctrl, rd);
            check_all();
            for (k = 0; k < 20; k++) begin
                s = (k == 5) ? 3 : $urandom_range(1, 2);
                axi_wr(STEP_OFFSET, 32'(s), rr);
                if (s == 1) idx = (idx + 1) % len;
                else if (s == 2) idx = (idx + len - 1) % len;
                check_all();
            end
        end
        axi_wr(CTRL_OFFSET, 32'h15, rr);
        settle(0);
        chk("alias mode code", 8'h0f, link.current_code);
        @(posedge aclk);
        s_axi_wstrb <= 4'h0;
        axi_wr(CTRL_OFFSET, 32'h0, rr);
        s_axi_wstrb <= 4'hf;
        settle(2);
        chk("masked write", 8'h0f, link.current_code);
        @(posedge aclk);
        overcurrent_trip <= 2'b01;
        settle(6);
        chk("ovc sources", 0, {source1_on[0], source2_on[0]});
        chk("ovc flag", 1, link.fault[FAULT_OVC]);
        @(posedge aclk);
        overcurrent_trip <= 2'b00;
        fault_current_zero <= 2'b01;
        settle(40);
        chk("ovc still off", 1, link.fault[FAULT_OVC]);
        settle(40);
        chk("ovc restart", 0, link.fault[FAULT_OVC]);
        @(posedge aclk);
        fault_current_zero <= 2'b00;
        temp_above_shutdown <= 1;
        temp_above_restart <= 1;
        settle(6);
        chk("thermal off", 0, {source1_on, source2_on, sink1_on, sink2_on});
        chk("thermal flag", 1, link.fault[FAULT_THERMAL]);
        @(posedge aclk);
        temp_above_shutdown <= 0;
        settle(6);
        chk("thermal hyst", 0, {source1_on, source2_on});
        @(posedge aclk);
        temp_above_restart <= 0;
        settle(6);
        chk("thermal on", 1, |(source1_on | source2_on));
        @(posedge aclk);
        supply_low <= 1;
        settle(6);
        chk("uvlo off", 0, {source1_on, source2_on, sink1_on, sink2_on});
        chk("uvlo flag", 1, link.fault[FAULT_UVLO]);
        @(posedge aclk);
        supply_low <= 0;
        settle(6);
        chk("uvlo on", 1, |(source1_on | source2_on));
        @(posedge aclk);
        chop_trip <= 2'b10;
        settle(6);
        chk("offtime sink", 0, sink1_on[1] | sink2_on[1]);
        @(posedge aclk);
        chop_trip <= 2'b00;
        settle(OFF_TIME_CYC);
        chk("sink back", 1, sink1_on[1] | sink2_on[1]);
        tally_and_finish();
    end

    // Whole run needs a few thousand cycles; this margin only cuts a hang
    initial begin
        repeat (40000) @(posedge aclk);
        error_cnt++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
